// File: common/sct_defines.svh
/*
 * Register offsets, reset values and field positions for the smart card
 * protocol timers. Assumes an 8-bit special function register port.
 */
`ifndef SCT_DEFINES_SVH
`define SCT_DEFINES_SVH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define SCT_ADDR_BWT3 16'hFE18
`define SCT_ADDR_BWT2 16'hFE19
`define SCT_ADDR_BWT1 16'hFE1A
`define SCT_ADDR_BWT0 16'hFE1B
`define SCT_ADDR_CWT1 16'hFE1C
`define SCT_ADDR_CWT0 16'hFE1D
`define SCT_ADDR_ATR1 16'hFE1F
`define SCT_ADDR_ATR0 16'hFE20
`define SCT_ADDR_FIRST_CHAR_LIMIT 16'hFE21
`define SCT_ADDR_RLEN 16'hFE22

// ----------------------------------------
// reset values and widths
// ----------------------------------------
`define SCT_RST_BYTE 8'h00
`define SCT_RST_RLEN 8'h70
`define SCT_BWT_TOP_MASK 8'h0F
`define SCT_BWT_W 28
`define SCT_CNT_W 28

`endif

// File: common/sct_pkg.sv
/*
 * Types shared by the smart card protocol timers.
 * Assumes sct_defines.svh is available on the include path.
 */
package sct_pkg;
	typedef enum logic [1:0] {
		SCT_RST_HELD,
		SCT_RST_DELAY,
		SCT_RST_FREE
	} sct_rst_state_t;
	typedef logic [27:0] sct_count_t;
endpackage

// File: common/sct_tick_if.sv
/*
 * Carries the per-ETU enable and character edge events between the
 * timer top and its leaves. Assumes one clock domain.
 */
`timescale 1ns/1ps
`default_nettype none
interface sct_tick_if;
	logic etuTick;
	logic startEdge;
	modport src (output etuTick, output startEdge);
	modport dst (input etuTick, input startEdge);
endinterface
`default_nettype wire

// File: hw/sct_limit_counter.sv
/*
 * Generic ETU counter compared against a limit; flags a timeout pulse.
 * Assumes run, restart and tick come from logic on the same clock.
 */
`timescale 1ns/1ps
`default_nettype none
module sct_limit_counter
	import sct_pkg::*;
#(
	parameter int WIDTH = 28
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// control
	input wire logic run,
	input wire logic restart,
	input wire logic [WIDTH-1:0] limit,
	sct_tick_if.dst tick,
	// status
	output logic expired,
	output logic [WIDTH-1:0] count
);
	logic done;

	// ----------------------------------------
	// counting
	// ----------------------------------------
	// done blocks repeated pulses until the next restart
	always_ff @(posedge clk) begin
		if (rst || !run || restart || tick.startEdge) begin
			count <= '0;
			done <= 1'b0;
			expired <= 1'b0;
		end else begin
			expired <= 1'b0;
			if (tick.etuTick && !done) begin
				count <= count + 1'b1;
				if (count + 1'b1 > limit) begin
					expired <= 1'b1;
					done <= 1'b1;
				end
			end
		end
	end
endmodule
`default_nettype wire

// File: hw/sct_reset_stretch.sv
/*
 * Card reset release delay. Holds reset while the request bit or a bad
 * supply stands, then counts reset-length ETUs. Inputs are synchronous.
 */
`timescale 1ns/1ps
`default_nettype none
module sct_reset_stretch
	import sct_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// control
	input wire logic cardResetRequest,
	input wire logic supplyGood,
	input wire logic [7:0] resetLength,
	sct_tick_if.dst tick,
	// card side
	output logic cardRstN,
	output logic releasePulse
);
	sct_rst_state_t state;
	logic [7:0] delayCount;

	// ----------------------------------------
	// release sequencing
	// ----------------------------------------
	always_ff @(posedge clk) begin
		if (rst) begin
			state <= SCT_RST_HELD;
			delayCount <= 8'h00;
			cardRstN <= 1'b0;
			releasePulse <= 1'b0;
		end else begin
			releasePulse <= 1'b0;
			case (state)
				SCT_RST_HELD: begin
					cardRstN <= 1'b0;
					delayCount <= 8'h00;
					// request held before power keeps card in reset, see R15
					if (supplyGood && !cardResetRequest) begin
						if (resetLength == 8'h00) begin
							state <= SCT_RST_FREE; // see R13
							cardRstN <= 1'b1;
							releasePulse <= 1'b1;
						end else begin
							state <= SCT_RST_DELAY;
						end
					end
				end
				SCT_RST_DELAY: begin
					if (cardResetRequest || !supplyGood) begin
						state <= SCT_RST_HELD;
					end else if (tick.etuTick) begin
						// release after reset-length ETUs, see R14
						if (delayCount + 8'h01 >= resetLength) begin
							state <= SCT_RST_FREE;
							cardRstN <= 1'b1;
							releasePulse <= 1'b1;
						end
						delayCount <= delayCount + 8'h01;
					end
				end
				SCT_RST_FREE: begin
					// setting the request drives reset low at once, see R14
					if (cardResetRequest || !supplyGood) begin
						state <= SCT_RST_HELD;
						cardRstN <= 1'b0;
					end
				end
				default: begin
					state <= SCT_RST_HELD;
					cardRstN <= 1'b0;
				end
			endcase
		end
	end

	heldWhileRequest_a: assert property (@(posedge clk) disable iff (rst) // see R14
		cardResetRequest |=> !cardRstN)
		else $error("card reset released while request set");
	releaseNeedsSupply_a: assert property (@(posedge clk) disable iff (rst) // see R13
		$rose(cardRstN) |-> $past(supplyGood))
		else $error("card reset released without supply good");
endmodule
`default_nettype wire

// File: hw/sct_protocol_timers.sv
/*
 * Smart card protocol timers: waiting time, character/initial waiting,
 * answer duration, first character timeout and card reset stretch.
 * Assumes an 8-bit register port on clk, and the ETU-rate clock and
 * the card I/O line both arriving asynchronously.
 */
// Operation
// R1: hold a 28-bit waiting limit in four bytes, top byte four bits only.
// R2: T=1: wait from last sent character start to first received start bit.
// R3: T=0: wait between leading edges of any two consecutive characters.
// R4: waiting or character waiting timeout raises an interrupt request.
// R5: firmware loads waiting limit before writing the final transmit byte.
// R6: 16-bit character limit checks spacing of received character start edges.
// R7: firmware switches initial and character limits itself.
// R8: 16-bit answer limit; flag timeout when answer lasts longer.
// R9: answer timer armed by receive-answer flag, starts at first start bit.
// R10: with detect enabled, 8-bit timer runs from reset release to first char.
// R11: first character missing within limit reports answer timeout, mute card.
// R12: 8-bit reset-length register, reset 0x70, delays card reset release.
// R13: zero length and no request releases reset once supply is good.
// R14: request drives reset low; clearing releases after reset-length delay.
// R15: request set before power holds reset until length after clearing.
// R16: counters advance per ETU tick and restart on qualifying start edges.
`timescale 1ns/1ps
`default_nettype none
`include "sct_defines.svh"
module sct_protocol_timers
	import sct_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// register port
	input wire logic [15:0] regAddr,
	input wire logic regWrite,
	input wire logic [7:0] regWdata,
	output logic [7:0] regRdata,
	// control bits from the card control registers
	input wire logic protocolT1,
	input wire logic receivingAnswerFlag,
	input wire logic firstCharDetectEnable,
	input wire logic cardResetRequest,
	input wire logic cardSupplyGood,
	// card line and timing
	input wire logic etuClkIn,
	input wire logic cardIoIn,
	input wire logic txCharStart,
	// card reset pin
	output logic cardRstN,
	// events
	output logic waitTimeoutIrq,
	output logic answerTimeout
);
	logic [7:0] blockWaitByte3;
	logic [7:0] blockWaitByte2;
	logic [7:0] blockWaitByte1;
	logic [7:0] blockWaitByte0;
	logic [7:0] charWaitHigh;
	logic [7:0] charWaitLow;
	logic [7:0] answerLimitHigh;
	logic [7:0] answerLimitLow;
	logic [7:0] firstCharLimit;
	logic [7:0] cardResetLength;
	logic ioSync1;
	logic ioSync2;
	logic ioLast;
	logic rxStart;
	logic supplySync1;
	logic supplySync2;
	logic etuSync1;
	logic etuSync2;
	logic etuLast;
	logic etuTick;
	logic [27:0] blockWaitLimit;
	logic blockRun;
	logic blockRestart;
	logic blockExpired;
	logic charRun;
	logic charExpired;
	logic answerRun;
	logic answerStarted;
	logic answerExpired;
	logic tsRun;
	logic tsExpired;
	logic releasePulse;
	logic answerSeen;

	sct_tick_if tickBlock();
	sct_tick_if tickChar();
	sct_tick_if tickOnly();

	// ----------------------------------------
	// synchronisers and start edge
	// ----------------------------------------
	// io line idles high; a start bit is its falling edge
	always_ff @(posedge clk) begin
		if (rst) begin
			ioSync1 <= 1'b1;
			ioSync2 <= 1'b1;
			ioLast <= 1'b1;
			supplySync1 <= 1'b0;
			supplySync2 <= 1'b0;
			etuSync1 <= 1'b0;
			etuSync2 <= 1'b0;
			etuLast <= 1'b0;
		end else begin
			ioSync1 <= cardIoIn;
			ioSync2 <= ioSync1;
			ioLast <= ioSync2;
			supplySync1 <= cardSupplyGood;
			supplySync2 <= supplySync1;
			etuSync1 <= etuClkIn;
			etuSync2 <= etuSync1;
			etuLast <= etuSync2;
		end
	end
	// a start edge outside reset release is noise, so gate it
	assign rxStart = ioLast && !ioSync2 && cardRstN;
	assign etuTick = etuSync2 && !etuLast; // rising edge of the ETU clock

	// ----------------------------------------
	// register file
	// ----------------------------------------
	always_ff @(posedge clk) begin
		if (rst) begin
			blockWaitByte3 <= `SCT_RST_BYTE;
			blockWaitByte2 <= `SCT_RST_BYTE;
			blockWaitByte1 <= `SCT_RST_BYTE;
			blockWaitByte0 <= `SCT_RST_BYTE;
			charWaitHigh <= `SCT_RST_BYTE;
			charWaitLow <= `SCT_RST_BYTE;
			answerLimitHigh <= `SCT_RST_BYTE;
			answerLimitLow <= `SCT_RST_BYTE;
			firstCharLimit <= `SCT_RST_BYTE;
			cardResetLength <= `SCT_RST_RLEN; // see R12
		end else if (regWrite) begin
			case (regAddr)
				`SCT_ADDR_BWT3: blockWaitByte3 <= regWdata & `SCT_BWT_TOP_MASK; // see R1
				`SCT_ADDR_BWT2: blockWaitByte2 <= regWdata;
				`SCT_ADDR_BWT1: blockWaitByte1 <= regWdata;
				`SCT_ADDR_BWT0: blockWaitByte0 <= regWdata;
				`SCT_ADDR_CWT1: charWaitHigh <= regWdata; // see R6
				`SCT_ADDR_CWT0: charWaitLow <= regWdata;
				`SCT_ADDR_ATR1: answerLimitHigh <= regWdata; // see R8
				`SCT_ADDR_ATR0: answerLimitLow <= regWdata;
				`SCT_ADDR_FIRST_CHAR_LIMIT: firstCharLimit <= regWdata;
				`SCT_ADDR_RLEN: cardResetLength <= regWdata;
				default: begin
				end
			endcase
		end
	end

	// read data registered: valid one cycle after regAddr; unmapped reads zero
	always_ff @(posedge clk) begin
		if (rst) begin
			regRdata <= 8'h00;
		end else begin
			case (regAddr)
				`SCT_ADDR_BWT3: regRdata <= blockWaitByte3;
				`SCT_ADDR_BWT2: regRdata <= blockWaitByte2;
				`SCT_ADDR_BWT1: regRdata <= blockWaitByte1;
				`SCT_ADDR_BWT0: regRdata <= blockWaitByte0;
				`SCT_ADDR_CWT1: regRdata <= charWaitHigh;
				`SCT_ADDR_CWT0: regRdata <= charWaitLow;
				`SCT_ADDR_ATR1: regRdata <= answerLimitHigh;
				`SCT_ADDR_ATR0: regRdata <= answerLimitLow;
				`SCT_ADDR_FIRST_CHAR_LIMIT: regRdata <= firstCharLimit;
				`SCT_ADDR_RLEN: regRdata <= cardResetLength;
				default: regRdata <= 8'h00;
			endcase
		end
	end

	assign blockWaitLimit = {blockWaitByte3[3:0], blockWaitByte2, blockWaitByte1,
		blockWaitByte0}; // see R1

	// ----------------------------------------
	// tick and edge distribution
	// ----------------------------------------
	assign tickBlock.etuTick = etuTick; // see R16
	assign tickBlock.startEdge = blockRestart;
	assign tickChar.etuTick = etuTick;
	assign tickChar.startEdge = rxStart;
	assign tickOnly.etuTick = etuTick;
	assign tickOnly.startEdge = 1'b0;

	// ----------------------------------------
	// block / work waiting time
	// ----------------------------------------
	// T=1 restarts on sent characters only and stops at the first received
	// start bit, so the next sent character rearms it
	always_ff @(posedge clk) begin
		if (rst) begin
			blockRun <= 1'b0;
		end else if (txCharStart) begin
			blockRun <= 1'b1;
		end else if (protocolT1 && rxStart) begin
			blockRun <= 1'b0; // see R2
		end else if (!protocolT1 && rxStart) begin
			blockRun <= 1'b1; // see R3
		end
	end
	assign blockRestart = txCharStart || (!protocolT1 && rxStart);

	sct_limit_counter #(.WIDTH(28)) blockTimer (
		.clk(clk),
		.rst(rst),
		.run(blockRun),
		.restart(blockRestart),
		.limit(blockWaitLimit),
		.tick(tickBlock),
		.expired(blockExpired),
		.count()
	);

	// ----------------------------------------
	// character / initial waiting time
	// ----------------------------------------
	always_ff @(posedge clk) begin
		if (rst || !cardRstN) begin
			charRun <= 1'b0;
		end else if (rxStart) begin
			charRun <= 1'b1; // see R6
		end
	end

	sct_limit_counter #(.WIDTH(16)) charTimer (
		.clk(clk),
		.rst(rst),
		.run(charRun),
		.restart(rxStart), // see R16
		.limit({charWaitHigh, charWaitLow}),
		.tick(tickChar),
		.expired(charExpired),
		.count()
	);

	// ----------------------------------------
	// answer duration
	// ----------------------------------------
	always_ff @(posedge clk) begin
		if (rst || !receivingAnswerFlag) begin
			answerStarted <= 1'b0; // see R9
		end else if (rxStart) begin
			answerStarted <= 1'b1;
		end
	end
	assign answerRun = receivingAnswerFlag && (answerStarted || rxStart);

	sct_limit_counter #(.WIDTH(16)) answerTimer (
		.clk(clk),
		.rst(rst),
		.run(answerRun),
		.restart(1'b0),
		.limit({answerLimitHigh, answerLimitLow}),
		.tick(tickOnly),
		.expired(answerExpired),
		.count()
	);

	// ----------------------------------------
	// first character timer
	// ----------------------------------------
	always_ff @(posedge clk) begin
		if (rst || !firstCharDetectEnable || !cardRstN) begin
			tsRun <= 1'b0;
			answerSeen <= 1'b0;
		end else if (releasePulse) begin
			tsRun <= 1'b1; // see R10
		end else if (rxStart && !answerSeen) begin
			tsRun <= 1'b0;
			answerSeen <= 1'b1;
		end
	end

	sct_limit_counter #(.WIDTH(8)) tsTimer (
		.clk(clk),
		.rst(rst),
		.run(tsRun),
		.restart(1'b0),
		.limit(firstCharLimit),
		.tick(tickOnly),
		.expired(tsExpired),
		.count()
	);

	// ----------------------------------------
	// card reset stretch and events
	// ----------------------------------------
	sct_reset_stretch resetStretch (
		.clk(clk),
		.rst(rst),
		.cardResetRequest(cardResetRequest),
		.supplyGood(supplySync2),
		.resetLength(cardResetLength),
		.tick(tickOnly),
		.cardRstN(cardRstN),
		.releasePulse(releasePulse)
	);

	always_ff @(posedge clk) begin
		if (rst) begin
			waitTimeoutIrq <= 1'b0;
			answerTimeout <= 1'b0;
		end else begin
			waitTimeoutIrq <= blockExpired || charExpired; // see R4
			answerTimeout <= answerExpired || tsExpired; // see R8, R11
		end
	end

	tsStopsOnEdge_a: assert property (@(posedge clk) disable iff (rst) // see R10
		(tsRun && rxStart && !answerSeen && !releasePulse && firstCharDetectEnable)
		|=> !tsRun)
		else $error("first character timer kept running after edge");
	answerDisarm_a: assert property (@(posedge clk) disable iff (rst) // see R9
		!receivingAnswerFlag |=> !answerStarted)
		else $error("answer timer armed without receive flag");
	waitIrqCause_a: assert property (@(posedge clk) disable iff (rst) // see R4
		$rose(waitTimeoutIrq) |-> $past(blockExpired || charExpired))
		else $error("wait interrupt without timer expiry");
	answerCause_a: assert property (@(posedge clk) disable iff (rst) // see R11
		$rose(answerTimeout) |-> $past(answerExpired || tsExpired))
		else $error("answer timeout without timer expiry");
	lengthReset_a: assert property (@(posedge clk) // see R12
		$past(rst) && !$past(regWrite) |-> cardResetLength == 8'h70)
		else $error("reset length lost its reset value");
	topNibble_a: assert property (@(posedge clk) disable iff (rst) // see R1
		blockWaitByte3[7:4] == 4'h0)
		else $error("waiting limit top byte holds upper bits");
	t1StopOnReply_a: assert property (@(posedge clk) disable iff (rst) // see R2
		(protocolT1 && rxStart && !txCharStart) |=> !blockRun)
		else $error("block timer kept running after reply");
	t0Restart_a: assert property (@(posedge clk) disable iff (rst) // see R3
		(!protocolT1 && rxStart) |=> blockRun)
		else $error("work wait timer not restarted by character");
endmodule
`default_nettype wire

// File: testbench/sct_card_model.sv
/*
 * Card stand-in: drives the card I/O contact one ETU at a time.
 * Assumes etuClk is the ETU-rate link clock made by the bench.
 */
`timescale 1ns/1ps
`default_nettype none
module sct_card_model (
	// link side
	input wire logic etuClk,
	// card line
	output logic cardIo
);
	// contact has a pull-up, so the idle line reads high
	initial cardIo = 1'b1;
	// data bits kept high: one falling edge per character, no false starts
	task automatic send_char();
		@(posedge etuClk);
		cardIo <= 1'b0;
		@(posedge etuClk);
		cardIo <= 1'b1;
	endtask
endmodule
`default_nettype wire

// File: testbench/sct_protocol_timers_test.sv
/*
 * Self-checking bench for the protocol timers: register port, card
 * reset stretch and the supervision timers. Assumes the card model,
 * the package and the interface are compiled first.
 */
`timescale 1ns/1ps
`default_nettype none
`include "sct_defines.svh"
module sct_protocol_timers_test;
	logic clk = 1'b0, rst = 1'b1, etuClk = 1'b0;
	logic [15:0] regAddr = 16'h0000;
	logic regWrite = 1'b0;
	logic [7:0] regWdata = 8'h00;
	logic [7:0] regRdata;
	logic protocolT1 = 1'b0, receivingAnswerFlag = 1'b0, firstCharDetectEnable = 1'b0;
	logic cardResetRequest = 1'b1, cardSupplyGood = 1'b0, txCharStart = 1'b0;
	logic cardIo, cardRstN, waitTimeoutIrq, answerTimeout;
	int miscompares = 0, check_count = 0, irqSeen = 0, atoSeen = 0;
	logic [15:0] addrs [10] = '{16'hFE18, 16'hFE19, 16'hFE1A, 16'hFE1B, 16'hFE1C,
		16'hFE1D, 16'hFE1F, 16'hFE20, 16'hFE21, 16'hFE22};

	always #2 clk = ~clk;
	always #62.5 etuClk = ~etuClk;
	always @(posedge clk) begin
		if (waitTimeoutIrq === 1'b1) irqSeen++;
		if (answerTimeout === 1'b1) atoSeen++;
	end

	sct_protocol_timers dut_u (.clk(clk), .rst(rst), .regAddr(regAddr),
		.regWrite(regWrite), .regWdata(regWdata), .regRdata(regRdata),
		.protocolT1(protocolT1), .receivingAnswerFlag(receivingAnswerFlag),
		.firstCharDetectEnable(firstCharDetectEnable),
		.cardResetRequest(cardResetRequest), .cardSupplyGood(cardSupplyGood),
		.etuClkIn(etuClk), .cardIoIn(cardIo), .txCharStart(txCharStart),
		.cardRstN(cardRstN), .waitTimeoutIrq(waitTimeoutIrq),
		.answerTimeout(answerTimeout));
	sct_card_model card_u (.etuClk(etuClk), .cardIo(cardIo));

	// ----
	// tasks
	// ----
	task automatic check_val(input string what, input logic [7:0] exp, input logic [7:0] got);
		check_count++;
		if (got !== exp) begin
			miscompares++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		cyc(1);
		regAddr = a;
		regWdata = d;
		regWrite = 1'b1;
		cyc(1);
		regWrite = 1'b0;
	endtask
	task automatic rd_chk(input logic [15:0] a, input logic [7:0] exp);
		cyc(1);
		regAddr = a;
		cyc(1);
		check_val("regRdata", exp, regRdata);
	endtask
	// six cycles cover the ETU clock synchroniser and the output stage
	task automatic etus(input int n);
		repeat (n) @(posedge etuClk);
		cyc(6);
	endtask
	task automatic tx_start();
		cyc(1);
		txCharStart = 1'b1;
		cyc(1);
		txCharStart = 1'b0;
	endtask
	task automatic pulses(input int wexp, input int aexp);
		check_val("waitTimeoutIrq pulses", 8'(wexp), 8'(irqSeen));
		check_val("answerTimeout pulses", 8'(aexp), 8'(atoSeen));
		irqSeen = 0;
		atoSeen = 0;
	endtask
	task automatic wait_rst_high(input int maxCyc);
		int k;
		for (k = 0; k < maxCyc && cardRstN !== 1'b1; k++) cyc(1);
		check_val("cardRstN", 8'h01, {7'h00, cardRstN});
		if (cardRstN !== 1'b1) wrap_up();
	endtask
	task automatic wrap_up();
		$display("checks %0d miscompares %0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	// ----
	// stimulus
	// ----
	initial begin
		cyc(12);
		rst = 1'b0;
		foreach (addrs[i]) rd_chk(addrs[i], addrs[i] == 16'hFE22 ? 8'h70 : 8'h00);
		wr(16'hFE1E, 8'hA5);
		rd_chk(16'hFE1E, 8'h00);
		foreach (addrs[i]) wr(addrs[i], 8'hFF);
		foreach (addrs[i]) rd_chk(addrs[i], addrs[i] == 16'hFE18 ? 8'h0F : 8'hFF);
		// request set before power: held until length after clearing
		wr(`SCT_ADDR_RLEN, 8'h03);
		cardSupplyGood = 1'b1;
		etus(6);
		check_val("cardRstN", 8'h00, {7'h00, cardRstN});
		cardResetRequest = 1'b0;
		etus(2);
		check_val("cardRstN", 8'h00, {7'h00, cardRstN});
		wait_rst_high(45);
		cardResetRequest = 1'b1;
		cyc(3);
		check_val("cardRstN", 8'h00, {7'h00, cardRstN});
		wr(`SCT_ADDR_RLEN, 8'h00);
		cardResetRequest = 1'b0;
		wait_rst_high(4);
		// mute card, then a prompt one
		wr(`SCT_ADDR_FIRST_CHAR_LIMIT, 8'h04);
		firstCharDetectEnable = 1'b1;
		cardResetRequest = 1'b1;
		cyc(3);
		pulses(0, 0);
		cardResetRequest = 1'b0;
		wait_rst_high(4);
		etus(3);
		pulses(0, 0);
		etus(4);
		pulses(0, 1);
		cardResetRequest = 1'b1;
		cyc(3);
		cardResetRequest = 1'b0;
		wait_rst_high(4);
		card_u.send_char();
		etus(8);
		pulses(0, 0);
		firstCharDetectEnable = 1'b0;
		// work waiting in T=0
		for (int i = 0; i < 4; i++) wr(16'hFE18 + 16'(i), i == 3 ? 8'h05 : 8'h00);
		tx_start();
		etus(4);
		pulses(0, 0);
		etus(3);
		pulses(1, 0);
		tx_start();
		repeat (4) begin
			card_u.send_char();
			etus(1);
		end
		pulses(0, 0);
		etus(6);
		pulses(1, 0);
		// block waiting in T=1
		protocolT1 = 1'b1;
		tx_start();
		etus(2);
		card_u.send_char();
		etus(8);
		pulses(0, 0);
		tx_start();
		etus(8);
		pulses(1, 0);
		// character spacing, limit loaded while the card is held in reset
		cardResetRequest = 1'b1;
		wr(`SCT_ADDR_CWT1, 8'h00);
		wr(`SCT_ADDR_CWT0, 8'h04);
		cardResetRequest = 1'b0;
		wait_rst_high(4);
		card_u.send_char();
		etus(1);
		card_u.send_char();
		etus(2);
		pulses(0, 0);
		etus(5);
		pulses(1, 0);
		// answer duration, disarmed then overrun
		wr(`SCT_ADDR_CWT0, 8'hFF);
		wr(`SCT_ADDR_ATR1, 8'h00);
		wr(`SCT_ADDR_ATR0, 8'h06);
		receivingAnswerFlag = 1'b1;
		card_u.send_char();
		etus(1);
		card_u.send_char();
		receivingAnswerFlag = 1'b0;
		etus(10);
		pulses(0, 0);
		receivingAnswerFlag = 1'b1;
		card_u.send_char();
		etus(9);
		pulses(0, 1);
		wrap_up();
	end
endmodule
`default_nettype wire
